// ### opt_pkg.sv
// shared constants, register map and types for the one-shot / pwm timer channel
package opt_pkg;

    // register byte offsets on the apb slave
    localparam logic [7:0] OFS_CTRL0   = 8'h00; // count enable, count clock select
    localparam logic [7:0] OFS_CTRL1   = 8'h04; // mode select, software trigger
    localparam logic [7:0] OFS_EDGE    = 8'h08; // edge_select_control
    localparam logic [7:0] OFS_PERIOD  = 8'h0c; // period_compare
    localparam logic [7:0] OFS_DUTY    = 8'h10; // duty_compare
    localparam logic [7:0] OFS_COUNT   = 8'h14; // counter_read_buffer
    localparam logic [7:0] OFS_CAPEDGE = 8'h18; // capture_edge_control
    localparam logic [7:0] OFS_OPTION  = 8'h1c; // option_register
    localparam logic [7:0] OFS_STATUS  = 8'h20; // channel state

    // field positions
    localparam int CE_BIT      = 0;
    localparam int CKS_LSB     = 1;
    localparam int MODE_LSB    = 0;
    localparam int SWTRIG_BIT  = 6;
    localparam int TRIG_ES_LSB = 0;
    localparam int EVT_ES_LSB  = 2;

    // mode select field encodings
    localparam logic [2:0] MODE_ONESHOT = 3'h3;
    localparam logic [2:0] MODE_PWM     = 3'h4;

    // edge select encodings
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // count clock select value that takes the external event input
    localparam logic [2:0] CKS_EVENT = 3'h7;

    // counter limits and reset values
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_MAX  = 16'hffff;
    localparam logic [15:0] CNT_ONE  = 16'h0001;
    localparam logic [7:0]  EDGE_RST = 8'h00;

    // channel states
    typedef enum logic [1:0] {
        OPT_IDLE = 2'b00,
        OPT_WAIT = 2'b01,
        OPT_RUN  = 2'b10,
        OPT_PWM  = 2'b11
    } opt_state_t;

    // control word carried together
    typedef struct packed {
        logic [2:0] mode;
        logic [2:0] cks;
        logic       enable;
    } opt_ctrl_t;

    // compare pair carried together
    typedef struct packed {
        logic [15:0] period;
        logic [15:0] duty;
    } opt_cmp_t;

endpackage

// ### opt_timer.sv
// one-shot pulse and pwm output timer channel with apb register access
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - one-shot compare rewrites act at once; lower value wraps through ffff to 0.
// - one-shot: duty match asserts pulse, irq1; period match deasserts, irq0, halts.
// - one-shot delay from trigger to pulse is duty value count clocks.
// - one-shot duty irq fires in the cycle the count equals duty value.
// - mode value 100 selects pwm; count enable makes the pwm waveform.
// - pwm square output is 50% duty, half period period value plus one.
// - pwm start moves counter from ffff to 0 then counts each count clock.
// - pwm period is period value plus one; active width is duty value.
// - pwm compares use buffers, loaded from registers at start and at the period clear.
// - pwm period irq fires on the clear after period buffer match.
// - pwm duty irq fires in the cycle count equals duty buffer.
// - only a duty register write arms a buffer transfer; written last.
// - duty zero gives 0% output; both irqs fire together at the clear.
// - duty equal period plus one gives 100%, impossible with period ffff.
// - capture edge control and option register have no effect here.
// - edge control holds event input edge field and trigger edge field.
// - counter read register returns the live counter.
// - clock select written with count enable applies to that counting.
// - mode 011 is one-shot; enable waits for trigger, then counts from zero.
// - one-shot trigger is trigger input edge or the software trigger bit.
// - triggers during a one-shot pulse are ignored.
// - after the pulse the counter returns to zero, stops, waits for trigger.
module opt_timer (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pins
    input  wire logic        trigger_input,
    input  wire logic        event_count_input,
    output logic             square_output,
    output logic             pulse_output,
    // compare events, one mclk wide
    output logic             compare_irq_period,
    output logic             compare_irq_duty
);

    //////////////////////////////////////////////////////////////////////////
    // register state
    opt_pkg::opt_ctrl_t  ctrl;
    opt_pkg::opt_cmp_t   cmp;
    opt_pkg::opt_cmp_t   buf_q;
    opt_pkg::opt_state_t state;
    logic [7:0]          edge_select_control;
    logic [7:0]          capture_edge_control;
    logic [7:0]          option_register;
    logic [15:0]         cnt;
    logic                armed;
    logic                primed;
    logic                sw_trig;
    logic                en_q;
    logic [6:0]          div_cnt;
    logic                trig_q;
    logic                evt_q;

    // divider terminal value per clock select, 2**cks count
    function automatic logic [6:0] div_last(input logic [2:0] sel);
        div_last = 7'((7'h01 << sel) - 7'h01);
    endfunction

    // edge detect against the chosen edge encoding
    function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                      input logic cur);
        unique case (sel)
            opt_pkg::EDGE_NONE: edge_hit = 1'b0;
            opt_pkg::EDGE_RISE: edge_hit = cur & ~prev;
            opt_pkg::EDGE_FALL: edge_hit = prev & ~cur;
            opt_pkg::EDGE_BOTH: edge_hit = cur ^ prev;
        endcase
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // apb decode
    wire logic setup    = psel & ~penable;
    wire logic acc      = psel & penable;
    wire logic wr       = acc & pwrite;
    wire logic hit_ctl0 = paddr == opt_pkg::OFS_CTRL0;
    wire logic hit_ctl1 = paddr == opt_pkg::OFS_CTRL1;
    wire logic hit_edge = paddr == opt_pkg::OFS_EDGE;
    wire logic hit_per  = paddr == opt_pkg::OFS_PERIOD;
    wire logic hit_duty = paddr == opt_pkg::OFS_DUTY;
    wire logic hit_cnt  = paddr == opt_pkg::OFS_COUNT;
    wire logic hit_cap  = paddr == opt_pkg::OFS_CAPEDGE;
    wire logic hit_opt  = paddr == opt_pkg::OFS_OPTION;
    wire logic hit_stat = paddr == opt_pkg::OFS_STATUS;
    wire logic mapped   = hit_ctl0 | hit_ctl1 | hit_edge | hit_per | hit_duty
                        | hit_cnt | hit_cap | hit_opt | hit_stat;
    wire logic wr_duty  = wr & hit_duty;

    // zero wait states; error only in the access phase of an unmapped address
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    // read mux, sampled into prdata at setup so the answer is a flop
    logic [31:0] next_prdata;
    always_comb begin
        next_prdata = '0;
        if (hit_ctl0) begin
            next_prdata[opt_pkg::CKS_LSB +: 3] = ctrl.cks;
            next_prdata[opt_pkg::CE_BIT]       = ctrl.enable;
        end
        if (hit_ctl1) next_prdata[opt_pkg::MODE_LSB +: 3] = ctrl.mode;
        if (hit_edge) next_prdata[7:0] = edge_select_control;
        if (hit_per)  next_prdata[15:0] = cmp.period;
        if (hit_duty) next_prdata[15:0] = cmp.duty;
        if (hit_cnt)  next_prdata[15:0] = cnt;
        if (hit_cap)  next_prdata[7:0] = capture_edge_control;
        if (hit_opt)  next_prdata[7:0] = option_register;
        if (hit_stat) next_prdata[3:0] = {armed, primed, state};
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            prdata <= '0;
        end else if (setup) begin
            prdata <= next_prdata;
        end
    end

    // register writes; capture and option are storage only
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl                 <= '0;
            cmp                  <= '0;
            edge_select_control  <= opt_pkg::EDGE_RST;
            capture_edge_control <= opt_pkg::EDGE_RST;
            option_register      <= opt_pkg::EDGE_RST;
            sw_trig              <= 1'b0;
        end else begin
            sw_trig <= wr & hit_ctl1 & pwdata[opt_pkg::SWTRIG_BIT];
            if (wr & hit_ctl0) begin
                ctrl.enable <= pwdata[opt_pkg::CE_BIT];
                ctrl.cks    <= pwdata[opt_pkg::CKS_LSB +: 3];
            end
            if (wr & hit_ctl1) ctrl.mode <= pwdata[opt_pkg::MODE_LSB +: 3];
            if (wr & hit_edge) edge_select_control <= pwdata[7:0];
            if (wr & hit_per)  cmp.period <= pwdata[15:0];
            if (wr_duty)       cmp.duty <= pwdata[15:0];
            if (wr & hit_cap)  capture_edge_control <= pwdata[7:0];
            if (wr & hit_opt)  option_register <= pwdata[7:0];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // count clock and trigger; divider restarts with enable so the new
    // selection governs the counting that begins in the same write
    wire logic start    = ctrl.enable & ~en_q;
    wire logic evt_edge = edge_hit(edge_select_control[opt_pkg::EVT_ES_LSB +: 2],
                                   evt_q, event_count_input);
    wire logic div_end  = div_cnt == div_last(ctrl.cks);
    wire logic tick     = ctrl.enable & ~start
                        & ((ctrl.cks == opt_pkg::CKS_EVENT) ? evt_edge : div_end);
    wire logic trig     = sw_trig
                        | edge_hit(edge_select_control[opt_pkg::TRIG_ES_LSB +: 2],
                                   trig_q, trigger_input);

    always_ff @(posedge mclk) begin
        if (reset) begin
            en_q    <= 1'b0;
            div_cnt <= '0;
            trig_q  <= 1'b0;
            evt_q   <= 1'b0;
        end else begin
            en_q    <= ctrl.enable;
            trig_q  <= trigger_input;
            evt_q   <= event_count_input;
            div_cnt <= (start | div_end | ~ctrl.enable) ? '0 : 7'(div_cnt + 7'h01);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // one-shot compares read the registers directly; the 16-bit add wraps
    // through ffff to zero, so a lowered value is met only after overflow
    wire logic        os_mode  = ctrl.mode == opt_pkg::MODE_ONESHOT;
    wire logic        pwm_mode = ctrl.mode == opt_pkg::MODE_PWM;
    wire logic [15:0] cnt_inc  = 16'(cnt + opt_pkg::CNT_ONE);
    wire logic        os_end   = tick & (cnt == cmp.period);
    wire logic        os_go    = trig & (state == opt_pkg::OPT_WAIT);

    // pwm: first tick after start leaves ffff; afterwards clear on buffer match
    wire logic        pwm_wrap = primed | (cnt == buf_q.period);
    wire logic        pwm_irq0 = tick & ~primed & (cnt == buf_q.period);
    wire logic        load     = tick & pwm_wrap & armed;
    wire logic [15:0] pwm_next = pwm_wrap ? opt_pkg::CNT_ZERO : cnt_inc;
    wire logic [15:0] duty_nx  = load ? cmp.duty : buf_q.duty;

    //////////////////////////////////////////////////////////////////////////
    // channel sequencing
    always_ff @(posedge mclk) begin
        if (reset) begin
            state              <= opt_pkg::OPT_IDLE;
            cnt                <= opt_pkg::CNT_ZERO;
            buf_q              <= '0;
            armed              <= 1'b0;
            primed             <= 1'b0;
            square_output      <= 1'b0;
            pulse_output       <= 1'b0;
            compare_irq_period <= 1'b0;
            compare_irq_duty   <= 1'b0;
        end else begin
            compare_irq_period <= 1'b0;
            compare_irq_duty   <= 1'b0;
            // a new duty write wins over a transfer in the same cycle
            armed <= wr_duty | (armed & ~load);
            if (!ctrl.enable) begin
                // stop at once, outputs inactive, count held for reading
                state         <= opt_pkg::OPT_IDLE;
                square_output <= 1'b0;
                pulse_output  <= 1'b0;
            end else if (start) begin
                cnt           <= opt_pkg::CNT_MAX;
                primed        <= 1'b1;
                buf_q         <= cmp;
                square_output <= 1'b0;
                pulse_output  <= 1'b0;
                state         <= pwm_mode ? opt_pkg::OPT_PWM
                               : os_mode  ? opt_pkg::OPT_WAIT : opt_pkg::OPT_IDLE;
            end else begin
                unique case (state)
                    opt_pkg::OPT_IDLE: begin
                        pulse_output <= 1'b0;
                    end
                    opt_pkg::OPT_WAIT: begin
                        if (os_go) begin
                            cnt           <= opt_pkg::CNT_ZERO;
                            state         <= opt_pkg::OPT_RUN;
                            square_output <= 1'b1;
                        end
                    end
                    opt_pkg::OPT_RUN: begin
                        if (os_end) begin
                            cnt                <= opt_pkg::CNT_ZERO;
                            state              <= opt_pkg::OPT_WAIT;
                            pulse_output       <= 1'b0;
                            square_output      <= 1'b0;
                            compare_irq_period <= 1'b1;
                        end else if (tick) begin
                            cnt <= cnt_inc;
                            // irq and pin change in the cycle the count lands on it
                            if (cnt_inc == cmp.duty) begin
                                pulse_output     <= 1'b1;
                                compare_irq_duty <= 1'b1;
                            end
                        end
                    end
                    opt_pkg::OPT_PWM: begin
                        if (tick) begin
                            cnt    <= pwm_next;
                            primed <= 1'b0;
                            if (load) buf_q <= cmp;
                            compare_irq_period <= pwm_irq0;
                            if (pwm_irq0) square_output <= ~square_output;
                            // duty zero meets the clear, so both irqs coincide
                            compare_irq_duty <= pwm_next == duty_nx;
                            // duty of period plus one is never reached: 100%
                            pulse_output <= pwm_next < duty_nx;
                        end
                    end
                endcase
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_pwm_period_clear: assert property (
        (state == opt_pkg::OPT_PWM && ctrl.enable && tick && !primed
         && cnt == buf_q.period) |=> (cnt == opt_pkg::CNT_ZERO && compare_irq_period))
        else $error("pwm period match did not clear with irq");
    a_pwm_duty_irq: assert property (
        (state == opt_pkg::OPT_PWM && compare_irq_duty) |-> cnt == buf_q.duty)
        else $error("pwm duty irq without duty match");
    a_pwm_out_level: assert property (
        (state == opt_pkg::OPT_PWM && !primed) |-> pulse_output == (cnt < buf_q.duty))
        else $error("pwm output level wrong");
    a_square_half_toggle: assert property (
        (state == opt_pkg::OPT_PWM && compare_irq_period)
        |-> square_output != $past(square_output))
        else $error("square output missed toggle");
    a_pwm_start_max: assert property (
        (ctrl.enable && !en_q && pwm_mode) |=> (cnt == opt_pkg::CNT_MAX && primed))
        else $error("pwm start did not load ffff");
    a_os_halt_zero: assert property (
        (os_mode && compare_irq_period)
        |-> (state == opt_pkg::OPT_WAIT && cnt == opt_pkg::CNT_ZERO && !pulse_output))
        else $error("one-shot did not halt at zero");
    a_os_duty_assert: assert property (
        (state == opt_pkg::OPT_RUN && compare_irq_duty) |-> (pulse_output && cnt == cmp.duty))
        else $error("one-shot duty irq not aligned with pulse");
    a_os_trig_ignore: assert property (
        (state == opt_pkg::OPT_RUN && trig && !os_end && ctrl.enable)
        |=> (state == opt_pkg::OPT_RUN
             && cnt == ($past(tick) ? $past(cnt_inc) : $past(cnt))))
        else $error("one-shot retriggered while running");
    a_disable_quiet: assert property (
        !ctrl.enable |=> (!pulse_output && !square_output))
        else $error("outputs active after disable");
    a_cnt_read_live: assert property (
        (setup && hit_cnt) |=> prdata[15:0] == $past(cnt))
        else $error("counter read not live");
    // corner duties, buffer hold and one-shot entry
    a_pwm_zero_duty: assert property (
        (state == opt_pkg::OPT_PWM && compare_irq_period
         && buf_q.duty == opt_pkg::CNT_ZERO) |-> compare_irq_duty)
        else $error("zero duty did not raise both irqs");
    a_pwm_full_duty: assert property (
        (state == opt_pkg::OPT_PWM && !primed && buf_q.duty > buf_q.period) |-> pulse_output)
        else $error("full duty output dropped");
    a_buf_hold_unarmed: assert property (
        (state == opt_pkg::OPT_PWM && tick && !primed && !armed && cnt == buf_q.period)
        |=> buf_q == $past(buf_q))
        else $error("buffers loaded without a duty write");
    a_square_steady: assert property (
        (state == opt_pkg::OPT_PWM && !compare_irq_period) |-> $stable(square_output))
        else $error("square output moved off the period clear");
    a_os_start_zero: assert property (
        (os_go && ctrl.enable) |=> (state == opt_pkg::OPT_RUN && cnt == opt_pkg::CNT_ZERO
                                    && square_output))
        else $error("one-shot trigger did not start from zero");
    a_disable_no_irq: assert property (
        !ctrl.enable |=> (!compare_irq_period && !compare_irq_duty))
        else $error("compare event while disabled");

    c_pwm_wrap: cover property (state == opt_pkg::OPT_PWM && compare_irq_period);
    c_os_done: cover property (os_mode && compare_irq_period);
    c_zero_duty: cover property (compare_irq_period && compare_irq_duty);
    c_buf_load: cover property (load);
    c_os_retrig: cover property (state == opt_pkg::OPT_RUN && trig);

endmodule

// ### opt_timer_tb.sv
// self-checking testbench for the one-shot / pwm timer channel
`timescale 1ns/100ps

module opt_timer_tb;
    //////////////////////////////////////////////////////////////////////////////
    // design signals and bench counters
    logic        mclk;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        trigger_input;
    logic        event_count_input;
    logic        square_output;
    logic        pulse_output;
    logic        compare_irq_period;
    logic        compare_irq_duty;
    logic [31:0] rd;
    logic        err_seen;
    int          num_errors;
    int          checks_done;

    opt_timer i_dut (
        .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trigger_input(trigger_input),
        .event_count_input(event_count_input), .square_output(square_output),
        .pulse_output(pulse_output), .compare_irq_period(compare_irq_period),
        .compare_irq_duty(compare_irq_duty)
    );

    // free-running 50 MHz clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    //////////////////////////////////////////////////////////////////////////////
    // comparison, verdict and bus tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] expct);
        checks_done++;
        if (seen !== expct) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expct);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // one apb transfer; request held until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge mclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge mclk);
            if (pready === 1'b1)
                break;
        end
        // answer taken at the accepting edge, release only after it
        rd = prdata;
        err_seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n == 16) begin
            num_errors++;
            $display("Error at %0t: no ready, seen %h expected %h", $time, pready, 1'b1);
            tally_and_finish();
        end
    endtask

    function automatic logic pick(input int which);
        case (which)
            0: pick = compare_irq_period;
            1: pick = square_output;
            default: pick = pulse_output;
        endcase
    endfunction

    // bounded wait for a level on an output, counting falling edges
    task automatic wait_for(input int which, input logic lvl, output int waited);
        waited = 0;
        do begin
            @(negedge mclk);
            waited++;
        end while (pick(which) !== lvl && waited < 5000);
        if (waited >= 5000) begin
            num_errors++;
            $display("Error at %0t: wait timed out, seen %h expected %h", $time, 1'b0, 1'b1);
            tally_and_finish();
        end
    endtask

    // one pwm period, from one period event up to the next
    task automatic measure(output int len, output int hi, output int nd, output logic tog);
        logic sq0;
        int   w;
        wait_for(0, 1'b1, w);
        len = 1;
        hi = int'(pulse_output);
        nd = int'(compare_irq_duty);
        sq0 = square_output;
        for (int i = 0; i < 5000; i++) begin
            @(negedge mclk);
            if (compare_irq_period === 1'b1)
                break;
            len++;
            hi += int'(pulse_output);
            nd += int'(compare_irq_duty);
        end
        tog = (square_output !== sq0);
    endtask

    // one-shot pulse: delay, width and end-of-pulse events
    task automatic oneshot(input int p, input int d);
        int w;
        wait_for(1, 1'b1, w);
        wait_for(2, 1'b1, w);
        check(w, d);
        check(compare_irq_duty, 1'b1);
        wait_for(2, 1'b0, w);
        check(w, p - d + 1);
        check({compare_irq_period, square_output}, 2'b10);
        apb(1'b0, opt_pkg::OFS_COUNT, 32'h0);
        check(rd, 32'h0);
    endtask

    //////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int p, d, ck, len, hi, nd, w;
        logic tog;
        logic [31:0] c1;
        num_errors = 0;
        checks_done = 0;
        reset = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        trigger_input = 1'b0;
        event_count_input = 1'b0;
        w = $urandom(84);
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        // reset values, unmapped access, storage-only registers
        for (int a = 0; a <= 8; a++) begin
            apb(1'b0, 8'(a * 4), 32'h0);
            check(rd, 32'h0);
        end
        apb(1'b0, 8'h24, 32'h0);
        check(rd, 32'h0);
        check(err_seen, 1'b1);
        c1 = $urandom;
        apb(1'b1, opt_pkg::OFS_CAPEDGE, c1);
        apb(1'b0, opt_pkg::OFS_CAPEDGE, 32'h0);
        check(rd, {24'h0, c1[7:0]});
        apb(1'b1, opt_pkg::OFS_OPTION, ~c1);
        apb(1'b1, opt_pkg::OFS_COUNT, c1);
        apb(1'b0, opt_pkg::OFS_COUNT, 32'h0);
        check(rd, 32'h0);
        $display("register test done");
        // pwm: 0%, 100% and random duty, each with its own count clock divide
        for (int t = 0; t < 5; t++) begin
            p = 8 + $urandom_range(30);
            d = (t == 0) ? 0 : (t == 1) ? p + 1 : $urandom_range(p, 1);
            ck = (t == 4) ? 1 : $urandom_range(2);
            if (t == 4) begin
                // event edges every second mclk give the same rate as divide by two
                apb(1'b1, opt_pkg::OFS_EDGE, {28'h0, opt_pkg::EDGE_RISE, opt_pkg::EDGE_NONE});
                fork
                    repeat (600) @(posedge mclk) event_count_input <= ~event_count_input;
                join_none
            end
            apb(1'b1, opt_pkg::OFS_PERIOD, 32'(p));
            apb(1'b1, opt_pkg::OFS_DUTY, 32'(d));
            apb(1'b1, opt_pkg::OFS_CTRL1, 32'(opt_pkg::MODE_PWM));
            apb(1'b1, opt_pkg::OFS_CTRL0,
                {28'h0, ((t == 4) ? opt_pkg::CKS_EVENT : 3'(ck)), 1'b1});
            measure(len, hi, nd, tog);
            check(len, (p + 1) << ck);
            check(hi, ((d > p) ? p + 1 : d) << ck);
            check(nd, (d <= p) ? 1 : 0);
            check(tog, 1'b1);
            apb(1'b0, opt_pkg::OFS_COUNT, 32'h0);
            check(rd <= 32'(p), 1'b1);
            if (t == 2) begin
                measure(len, hi, nd, tog);
                apb(1'b1, opt_pkg::OFS_PERIOD, 32'(p + 5));
                measure(len, hi, nd, tog);
                check(len, (p + 1) << ck);
                apb(1'b1, opt_pkg::OFS_DUTY, 32'(d));
                measure(len, hi, nd, tog);
                measure(len, hi, nd, tog);
                check(len, (p + 6) << ck);
            end
            apb(1'b1, opt_pkg::OFS_CTRL0, 32'h0);
            apb(1'b0, opt_pkg::OFS_COUNT, 32'h0);
            c1 = rd;
            apb(1'b0, opt_pkg::OFS_COUNT, 32'h0);
            check(rd, c1);
            check({square_output, pulse_output}, 2'b00);
            $display("pwm test %0d done", t);
        end
        // one-shot: inactive edge select, then software and input triggers
        p = 20 + $urandom_range(20);
        d = 2 + $urandom_range(8);
        apb(1'b1, opt_pkg::OFS_EDGE, {30'h0, opt_pkg::EDGE_NONE});
        apb(1'b1, opt_pkg::OFS_PERIOD, 32'(p));
        apb(1'b1, opt_pkg::OFS_DUTY, 32'(d));
        apb(1'b1, opt_pkg::OFS_CTRL1, 32'(opt_pkg::MODE_ONESHOT));
        apb(1'b1, opt_pkg::OFS_CTRL0, 32'h1);
        trigger_input <= 1'b1;
        repeat (4) @(posedge mclk);
        apb(1'b0, opt_pkg::OFS_COUNT, 32'h0);
        // a waiting counter sits at ffff until the trigger clears it
        check(rd, {16'h0, opt_pkg::CNT_MAX});
        check(square_output, 1'b0);
        apb(1'b1, opt_pkg::OFS_CTRL1, 32'h40 | 32'(opt_pkg::MODE_ONESHOT));
        oneshot(p, d);
        apb(1'b0, opt_pkg::OFS_CTRL1, 32'h0);
        check(rd, 32'(opt_pkg::MODE_ONESHOT));
        apb(1'b1, opt_pkg::OFS_EDGE, {30'h0, opt_pkg::EDGE_BOTH});
        // extra edges land while the pulse runs and must change nothing
        fork
            repeat (6) begin
                repeat (3) @(posedge mclk);
                trigger_input <= ~trigger_input;
            end
        join_none
        oneshot(p, d);
        $display("one-shot test done");
        tally_and_finish();
    end
endmodule
